// [design/power_mode_controller.sv]
// power mode controller: sequences sleep, deep-sleep, power-down and deep power-down
// assumes a classic wishbone master on clk_i, wake sources on asynchronous pins/domains
`timescale 1ns/100ps
module power_mode_controller
  import pmc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // core side
  input  wire logic        wfi_i,
  input  wire logic        irq_any_i,
  // asynchronous wake sources
  input  wire wake_src_s   wake_src_i,
  input  wire logic        reset_pin_i,
  input  wire logic        wake_pin_i,
  input  wire logic        wake_pin_timer_i,
  // gating outputs
  output gate_s            gate_o,
  output pmc_state_e       state_o
);

  // ============================================================
  // synchronisers for asynchronous inputs
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  assign raw_in = {wake_src_i, reset_pin_i, wake_pin_i, wake_pin_timer_i, irq_any_i};

  // two flops per input; only sync_b is read downstream
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  wake_src_s wake_s;
  logic      rst_pin_s;
  logic      wake_pin_s;
  logic      timer_s;
  logic      irq_s;
  assign {wake_s, rst_pin_s, wake_pin_s, timer_s, irq_s} = sync_b;

  // ============================================================
  // registers
  power_mode_e mode_sel;
  logic        dpd_lock;
  logic [15:0] periph_gate;
  logic [8:0]  osc_cfg;
  logic [5:0]  wake_en;
  pmc_state_e  state;
  logic        woke_flag;

  logic        bus_req;
  logic        page;
  logic [3:0]  ofs;
  logic        wr;
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign page    = adr_i[`PMC_PAGE_BIT];
  assign ofs     = adr_i[3:0];
  assign wr      = bus_req & we_i & sel_i[0];

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_o <= 1'b0;
    else       ack_o <= bus_req;
  end

  // mode selection written ahead of the wait-for-interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) mode_sel <= MODE_SLEEP;
    else if (wr && !page && ofs == `PMC_OFS_MODE)
      mode_sel <= power_mode_e'(dat_i[`PMC_MODE_LSB +: 2]);
  end

  // lock bit is write-once-set until reset
  always_ff @(posedge clk_i) begin
    if (rst_i) dpd_lock <= 1'b0;
    else if (wr && !page && ofs == `PMC_OFS_LOCK && dat_i[0])
      dpd_lock <= 1'b1;
  end

  // per-peripheral clock gate register
  always_ff @(posedge clk_i) begin
    if (rst_i) periph_gate <= `PMC_RST_PERCLK;
    else if (wr && !page && ofs == `PMC_OFS_PERCLK) begin
      periph_gate[7:0] <= dat_i[7:0];
      if (sel_i[1]) periph_gate[15:8] <= dat_i[15:8];
    end
  end

  // oscillator, brownout, divider and deep power-down wake config
  always_ff @(posedge clk_i) begin
    if (rst_i) osc_cfg <= `PMC_RST_OSCCFG;
    else if (wr && !page && ofs == `PMC_OFS_OSCCFG) begin
      osc_cfg[7:0] <= dat_i[7:0];
      if (sel_i[1]) osc_cfg[8] <= dat_i[8];
    end
  end

  // system wake enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) wake_en <= `PMC_RST_WAKEEN;
    else if (wr && page && ofs == `PMC_OFS_WAKEEN) wake_en <= dat_i[5:0];
  end

  // read mux
  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= 32'h0000_0000;
    else if (bus_req && !we_i) begin
      dat_o <= 32'h0000_0000;
      if (!page) begin
        unique case (ofs)
          `PMC_OFS_MODE:   dat_o[1:0]  <= mode_sel;
          `PMC_OFS_LOCK:   dat_o[0]    <= dpd_lock;
          `PMC_OFS_PERCLK: dat_o[15:0] <= periph_gate;
          `PMC_OFS_OSCCFG: dat_o[8:0]  <= osc_cfg;
          default:         dat_o       <= 32'h0000_0000;
        endcase
      end else begin
        unique case (ofs)
          `PMC_OFS_WAKEEN: dat_o[5:0]  <= wake_en;
          `PMC_OFS_STATUS: dat_o[3:0]  <= {woke_flag, state};
          default:         dat_o       <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ============================================================
  // wake decode
  logic deep_wake;
  logic dpd_wake;
  assign deep_wake = rst_pin_s | (|(wake_s & wake_en));
  assign dpd_wake  = (wake_pin_s & osc_cfg[`PMC_OSC_WAKEPIN])
                   | (rst_pin_s & osc_cfg[`PMC_OSC_RSTPIN])
                   | (timer_s & osc_cfg[`PMC_OSC_LPDPD]);

  // ============================================================
  // state machine
  pmc_state_e next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (wfi_i) begin
          unique case (mode_sel)
            MODE_SLEEP:      next_state = ST_SLEEP;
            MODE_DEEP_SLEEP: next_state = ST_DEEP_SLEEP;
            MODE_POWER_DOWN: next_state = ST_POWER_DOWN;
            MODE_DEEP_PD:    next_state = dpd_lock ? ST_SLEEP : ST_DEEP_PD;
          endcase
        end
      end
      ST_SLEEP:      if (irq_s || rst_pin_s) next_state = ST_RUN;
      ST_DEEP_SLEEP: if (deep_wake) next_state = ST_RUN;
      ST_POWER_DOWN: if (deep_wake) next_state = ST_RUN;
      ST_DEEP_PD:    if (dpd_wake) next_state = ST_RUN;
      default:       next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) state <= ST_RUN;
    else       state <= next_state;
  end

  // sticky flag: set on a return from low power, cleared by reading status
  logic clr_woke;
  logic set_woke;
  assign clr_woke = bus_req && !we_i && page && ofs == `PMC_OFS_STATUS;
  assign set_woke = state != ST_RUN && next_state == ST_RUN;
  always_ff @(posedge clk_i) begin
    if (rst_i)         woke_flag <= 1'b0;
    else if (set_woke) woke_flag <= 1'b1; // set wins over clear
    else if (clr_woke) woke_flag <= 1'b0;
  end

  // ============================================================
  // gating per state, registered
  gate_s next_gate;
  always_comb begin
    next_gate = '0;
    next_gate.rc_div_sel      = osc_cfg[`PMC_OSC_FRODIV_LSB +: 2];
    next_gate.ext_clk_sel_pin = osc_cfg[`PMC_OSC_EXTSEL];
    next_gate.lp_osc_run      = osc_cfg[`PMC_OSC_LPOSC];
    unique case (state)
      ST_RUN, ST_SLEEP: begin
        next_gate.core_clk_en      = (state == ST_RUN);
        next_gate.periph_clk_en    = periph_gate;
        next_gate.rc_osc_run       = 1'b1;
        next_gate.rc_osc_out_en    = 1'b1;
        next_gate.xtal_osc_run     = 1'b1;
        next_gate.pll_run          = 1'b1;
        next_gate.watchdog_osc_run = osc_cfg[`PMC_OSC_WDOG];
        next_gate.brownout_run     = osc_cfg[`PMC_OSC_BROWN];
        next_gate.analog_en        = 1'b1;
        next_gate.flash_on         = 1'b1;
        next_gate.chip_power_on    = 1'b1;
      end
      ST_DEEP_SLEEP: begin
        next_gate.rc_osc_run       = 1'b1;
        next_gate.watchdog_osc_run = osc_cfg[`PMC_OSC_WDOG];
        next_gate.brownout_run     = osc_cfg[`PMC_OSC_BROWN];
        next_gate.flash_on         = 1'b1;
        next_gate.flash_standby    = 1'b1;
        next_gate.chip_power_on    = 1'b1;
      end
      ST_POWER_DOWN: begin
        next_gate.watchdog_osc_run = osc_cfg[`PMC_OSC_WDOG];
        next_gate.brownout_run     = osc_cfg[`PMC_OSC_BROWN];
        next_gate.chip_power_on    = 1'b1;
      end
      ST_DEEP_PD: begin
        next_gate.lp_osc_run = osc_cfg[`PMC_OSC_LPOSC] & osc_cfg[`PMC_OSC_LPDPD];
      end
      default: next_gate = '0;
    endcase
  end

  // registered gate outputs; reset shows run mode with the crystal oscillator and PLL off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_o <= '0;
      gate_o.core_clk_en   <= 1'b1;
      gate_o.periph_clk_en <= `PMC_RST_PERCLK;
      gate_o.rc_osc_run    <= 1'b1;
      gate_o.rc_osc_out_en <= 1'b1;
      gate_o.flash_on      <= 1'b1;
      gate_o.analog_en     <= 1'b1;
      gate_o.chip_power_on <= 1'b1;
      gate_o.rc_div_sel    <= 2'h1;
    end else begin
      gate_o <= next_gate;
    end
  end

  assign state_o = state;

endmodule

// [shared/pmc_defs.svh]
// constants for the power mode controller: register offsets, fields, reset values
// assumes inclusion by bare name from the package only
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
// ============================================================
// register byte offsets
`define PMC_OFS_MODE      4'h0
`define PMC_OFS_LOCK      4'h4
`define PMC_OFS_PERCLK    4'h8
`define PMC_OFS_OSCCFG    4'hc
`define PMC_OFS_WAKEEN    4'h0
`define PMC_OFS_STATUS    4'h4
// register page select (address bit 4): 0 control, 1 wake/status
`define PMC_PAGE_BIT      4
// ============================================================
// field positions
`define PMC_MODE_LSB      0
`define PMC_OSC_WDOG      0
`define PMC_OSC_LPOSC     1
`define PMC_OSC_BROWN     2
`define PMC_OSC_FRODIV_LSB 3
`define PMC_OSC_EXTSEL    5
`define PMC_OSC_LPDPD     6
`define PMC_OSC_WAKEPIN   7
`define PMC_OSC_RSTPIN    8
// ============================================================
// reset values
`define PMC_RST_PERCLK    16'hffff
`define PMC_RST_OSCCFG    9'h008
`define PMC_RST_WAKEEN    6'h00
`endif

// [shared/pmc_pkg.sv]
// types for the power mode controller
// assumes the constants header is on the include path
package pmc_pkg;
  `include "pmc_defs.svh"
  // ============================================================
  // power modes as software requests them
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_DEEP_SLEEP,
    MODE_POWER_DOWN,
    MODE_DEEP_PD
  } power_mode_e;
  // ============================================================
  // controller states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_DEEP_SLEEP,
    ST_POWER_DOWN,
    ST_DEEP_PD
  } pmc_state_e;
  // ============================================================
  // wake source bundle (deep-sleep and power-down sources)
  typedef struct packed {
    logic pin_int;
    logic wdog_int;
    logic touch_int;
    logic usart_slv_int;
    logic spi_slv_int;
    logic i2c_slv_int;
  } wake_src_s;
  // ============================================================
  // gating outputs toward the clock, oscillator and analog blocks
  typedef struct packed {
    logic        core_clk_en;
    logic [15:0] periph_clk_en;
    logic        rc_osc_run;
    logic        rc_osc_out_en;
    logic [1:0]  rc_div_sel;
    logic        ext_clk_sel_pin;
    logic        xtal_osc_run;
    logic        pll_run;
    logic        watchdog_osc_run;
    logic        lp_osc_run;
    logic        brownout_run;
    logic        analog_en;
    logic        flash_on;
    logic        flash_standby;
    logic        chip_power_on;
  } gate_s;
endpackage

// [testbench/pmc_assertions.sv]
// checker for the power mode controller ports
// assumes it is bound to power_mode_controller and sees its ports only
`timescale 1ns/100ps
module pmc_checker
  import pmc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       ack_o,
  input  wire logic       wfi_i,
  input  wire logic       irq_any_i,
  input  wire gate_s      gate_o,
  input  wire pmc_state_e state_o
);
  // ============================================================
  // clocking and state history
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  pmc_state_e s1;
  pmc_state_e s2;
  logic       steady;
  // two older samples of the state, so gating has had time to land
  always_ff @(posedge clk_i) begin
    s1 <= state_o;
    s2 <= s1;
  end
  // state unchanged over three samples
  always_comb steady = (state_o == s1) && (s1 == s2);
  // ============================================================
  // assertions
  sleep_core_off_a: assert property (steady && state_o == ST_SLEEP |-> !gate_o.core_clk_en)
    else $error("core clock running in sleep");
  run_core_on_a: assert property (steady && state_o == ST_RUN |-> gate_o.core_clk_en)
    else $error("core clock stopped in run");
  ds_sources_a: assert property (steady && state_o == ST_DEEP_SLEEP |-> gate_o.rc_osc_run
    && !gate_o.rc_osc_out_en && gate_o.periph_clk_en == 16'h0000 && !gate_o.pll_run)
    else $error("deep-sleep clock gating wrong");
  ds_analog_a: assert property (steady && state_o == ST_DEEP_SLEEP |->
    !gate_o.analog_en && gate_o.flash_standby)
    else $error("deep-sleep analog or flash wrong");
  pd_off_a: assert property (steady && state_o == ST_POWER_DOWN |-> !gate_o.rc_osc_run
    && !gate_o.flash_on && !gate_o.analog_en && gate_o.periph_clk_en == 16'h0000)
    else $error("power-down gating wrong");
  dpd_power_a: assert property (steady && state_o == ST_DEEP_PD |-> !gate_o.chip_power_on)
    else $error("chip powered in deep power-down");
  wfi_entry_a: assert property (state_o == ST_RUN && wfi_i |-> ##[1:2] state_o != ST_RUN)
    else $error("no low-power entry on wait-for-interrupt");
  run_hold_a: assert property (state_o == ST_RUN && !wfi_i && !$past(wfi_i) |=>
    state_o == ST_RUN)
    else $error("left run without wait-for-interrupt");
  sleep_wake_a: assert property (state_o == ST_SLEEP && irq_any_i |-> ##[1:5] state_o == ST_RUN)
    else $error("interrupt did not end sleep");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
endmodule
bind power_mode_controller pmc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .wfi_i(wfi_i), .irq_any_i(irq_any_i), .gate_o(gate_o),
  .state_o(state_o));

// [testbench/core_model.sv]
// processor core stand-in: executes wait-for-interrupt and raises wake events
// assumes the bench asks for each sleep and chooses the wake lines
`timescale 1ns/100ps
module core_model
  import pmc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sleep_req_i,
  input  wire logic [7:0] wake_i,
  input  wire pmc_state_e state_i,
  output logic            wfi_o,
  output logic            irq_o,
  output logic            wake_pin_o,
  output wake_src_s       wake_src_o
);
  // ============================================================
  // idle values at time zero
  initial begin
    wfi_o = 1'b0;
    {irq_o, wake_pin_o, wake_src_o} = 8'h00;
  end
  // one-cycle wait-for-interrupt, only from run
  always @(posedge clk_i) wfi_o <= !rst_i && sleep_req_i && state_i == ST_RUN && !wfi_o;
  // wake lines stand only while asleep; pin stays inactive until its event
  always @(posedge clk_i) begin
    {irq_o, wake_pin_o, wake_src_o} <= (rst_i || state_i == ST_RUN) ? 8'h00 : wake_i;
  end
endmodule

// [testbench/power_mode_controller_tb.sv]
// bench for the power mode controller: register access and mode cycling
// assumes the core model drives wait-for-interrupt, interrupt, wake pin and wake sources; the bench drives reset pin and timer
`timescale 1ns/100ps
module power_mode_controller_tb
  import pmc_pkg::*;
;
  typedef struct packed {
    logic [1:0]  mode;
    pmc_state_e  st;
    logic [15:0] per;
    logic [4:0]  flg;  // rc osc, chip power, flash standby, watchdog osc, brownout
    logic [7:0]  wk;   // irq, wake pin, wake sources
  } row_s;
  // ============================================================
  // signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        go = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic        ack_o, wfi, irq, wpin;
  logic [7:0]  wk = 8'h00;
  logic        rpin = 1'b0;
  logic        tmr = 1'b0;
  wake_src_s   src;
  gate_s       gate;
  pmc_state_e  st;
  int          err_total = 0;
  int          checked = 0;
  row_s        rows [4] = '{
    '{2'h0, ST_SLEEP, 16'h00a5, 5'h1b, 8'h80},
    '{2'h1, ST_DEEP_SLEEP, 16'h0000, 5'h1f, 8'h20},
    '{2'h2, ST_POWER_DOWN, 16'h0000, 5'h0b, 8'h10},
    '{2'h3, ST_DEEP_PD, 16'h0000, 5'h00, 8'h40}};
  // 10 MHz clock
  always #50 clk_i = ~clk_i;
  power_mode_controller u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .wfi_i(wfi), .irq_any_i(irq), .wake_src_i(src), .reset_pin_i(rpin), .wake_pin_i(wpin),
    .wake_pin_timer_i(tmr), .gate_o(gate), .state_o(st));
  core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .sleep_req_i(go), .wake_i(wk),
    .state_i(st), .wfi_o(wfi), .irq_o(irq), .wake_pin_o(wpin), .wake_src_o(src));
  // ============================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang;
    err_total++;
    $display("ERROR %0t: wait ran out", $time);
    stop_test();
  endtask
  // classic single bus cycle, held until ack is seen
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
    n = 0;
    // ack is read at the rising edge itself, before the slave updates it
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) hang();
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  // wait for a state, then let gating settle
  task automatic wst(input pmc_state_e s);
    int n;
    n = 0;
    while (st !== s && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    if (st !== s) hang();
    repeat (3) @(negedge clk_i);
  endtask
  task automatic slp;
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  // ============================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 5'h08, 32'h0); chk(q, 32'h0000ffff);
    wb(1'b0, 5'h0c, 32'h0); chk(q, 32'h00000008);
    wb(1'b0, 5'h10, 32'h0); chk(q, 32'h0);
    wb(1'b1, 5'h18, 32'hffffffff);
    wb(1'b0, 5'h18, 32'h0); chk(q, 32'h0);
    wb(1'b1, 5'h0c, 32'h30);
    repeat (2) @(negedge clk_i);
    chk(gate.rc_div_sel, 2'h2);
    chk(gate.ext_clk_sel_pin, 1'b1);
    wb(1'b1, 5'h0c, 32'h8d);
    wb(1'b1, 5'h10, 32'h3f);
    wb(1'b1, 5'h08, 32'ha5);
    foreach (rows[i]) begin
      wb(1'b1, 5'h00, 32'(rows[i].mode));
      slp();
      wst(rows[i].st);
      chk(gate.core_clk_en, 1'b0);
      chk(gate.periph_clk_en, rows[i].per);
      chk({gate.rc_osc_run, gate.chip_power_on, gate.flash_standby, gate.watchdog_osc_run,
        gate.brownout_run}, rows[i].flg);
      @(posedge clk_i);
      wk <= rows[i].wk;
      wst(ST_RUN);
      @(posedge clk_i);
      wk <= 8'h00;
      chk(gate.core_clk_en, 1'b1);
    end
    // deep power-down left by the wake timer, then by the reset pin
    wb(1'b1, 5'h0c, 32'h1cd);
    slp();
    wst(ST_DEEP_PD);
    @(posedge clk_i);
    tmr <= 1'b1;
    wst(ST_RUN);
    @(posedge clk_i);
    tmr <= 1'b0;
    chk(gate.chip_power_on, 1'b1);
    slp();
    wst(ST_DEEP_PD);
    @(posedge clk_i);
    rpin <= 1'b1;
    wst(ST_RUN);
    @(posedge clk_i);
    rpin <= 1'b0;
    chk(gate.core_clk_en, 1'b1);
    wb(1'b1, 5'h04, 32'h1);
    wb(1'b1, 5'h00, 32'h3);
    slp();
    wst(ST_SLEEP);
    @(posedge clk_i);
    wk <= 8'h80;
    wst(ST_RUN);
    @(posedge clk_i);
    wk <= 8'h00;
    wb(1'b0, 5'h14, 32'h0); chk(q, 32'h8);
    wb(1'b0, 5'h14, 32'h0); chk(q, 32'h0);
    stop_test();
  end
  // overall limit on the run
  initial begin
    repeat (20000) @(posedge clk_i);
    hang();
  end
endmodule
